//--- design/wdt_pkg.sv
// Package: register map, field layout, timing counts and types of the watchdog block
package wdt_pkg;

    // Register byte addresses
    localparam logic [7:0] WDT_CTRL_ADDR = 8'h60;
    localparam logic [7:0] RST_CAUSE_ADDR = 8'h54;

    // Watchdog control register field positions
    localparam int IRQ_FLAG_BIT = 7;
    localparam int IRQ_EN_BIT = 6;
    localparam int SEL3_BIT = 5;
    localparam int UNLOCK_BIT = 4;
    localparam int RST_EN_BIT = 3;
    localparam int SEL_HI_BIT = 2;
    localparam int SEL_LO_BIT = 0;

    // Reset cause register field positions
    localparam int DEBUG_FLAG_BIT = 4;
    localparam int WDOG_FLAG_BIT = 3;
    localparam int BROWNOUT_FLAG_BIT = 2;
    localparam int EXT_FLAG_BIT = 1;
    localparam int POWERON_FLAG_BIT = 0;

    // Reset values
    localparam logic [7:0] WDT_CTRL_RESET = 8'h00;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam logic [2:0] UNLOCK_IDLE = 3'h0;

    // Timing: change window in system clocks, time-out base in oscillator cycles
    localparam logic [2:0] UNLOCK_CYCLES = 3'h4;
    localparam int BASE_OSC_CYCLES = 2048;
    localparam logic [3:0] SEL_MAX = 4'h9;
    localparam int CNT_W = 20;
    localparam int OSC_HZ = 128000;
    localparam int SYS_HZ = 100000000;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_STOPPED,
        MODE_IRQ,
        MODE_RESET,
        MODE_IRQ_RESET
    } wdt_mode_t;

    // Stored control fields
    typedef struct packed {
        logic irq_flag;
        logic irq_en;
        logic rst_en;
        logic [3:0] sel;
    } wdt_ctrl_t;

    // Stored reset cause flags
    typedef struct packed {
        logic debug;
        logic wdog;
        logic brownout;
        logic ext;
        logic poweron;
    } reset_cause_t;

    // Reset sources reported by the system reset generator
    typedef struct packed {
        logic debug;
        logic brownout;
        logic ext;
    } reset_src_t;

    localparam reset_cause_t CAUSE_RESET = '{debug: 1'b0, wdog: 1'b0, brownout: 1'b0,
                                             ext: 1'b0, poweron: 1'b1};

    // Mode from fuse and effective enables
    function automatic wdt_mode_t decode_mode(input logic fuse_n, input logic rst_en,
                                              input logic irq_en);
        if (!fuse_n) begin
            return MODE_RESET;
        end
        unique case ({rst_en, irq_en})
            2'b00: return MODE_STOPPED;
            2'b01: return MODE_IRQ;
            2'b10: return MODE_RESET;
            2'b11: return MODE_IRQ_RESET;
        endcase
    endfunction

    // Last count value of a time-out period; reserved codes use the longest
    function automatic logic [CNT_W-1:0] timeout_limit(input int base, input logic [3:0] sel);
        logic [3:0] sel_c;
        sel_c = (sel > SEL_MAX) ? SEL_MAX : sel;
        return CNT_W'((base << sel_c) - 1);
    endfunction

endpackage

//--- design/wdt_reset_cause.sv
// Watchdog control, time-out actions and reset cause flags
`timescale 1ns/1ps

module wdt_reset_cause
    import wdt_pkg::*;
#(
    parameter int BASE_OSC_CYCLES_P = BASE_OSC_CYCLES
) (
    input wire logic sys_clk_i, // System clock, 100 MHz
    input wire logic srst_i, // Power-on reset, synchronous
    input wire logic [7:0] addr_i, // Register address
    input wire logic [7:0] wdata_i, // Register write data
    input wire logic wr_i, // Write strobe
    input wire logic rd_i, // Read strobe
    output logic [7:0] rdata_o, // Read data, cycle after the strobe
    input wire logic osc_clk_i, // Watchdog oscillator, 128 kHz
    input wire logic restart_i, // Restart instruction executed
    input wire logic gie_i, // Global interrupt enable of the CPU
    input wire logic irq_ack_i, // Time-out vector executed
    input wire logic always_on_fuse_i, // Fuse, 0 means programmed
    input wire reset_src_t rst_src_i, // Other reset sources
    output logic irq_req_o, // Time-out interrupt request
    output logic sys_rst_req_o // Watchdog system reset pulse
);

    wdt_ctrl_t ctrl_reg;
    wdt_ctrl_t ctrl_next;
    reset_cause_t cause_reg;
    reset_cause_t cause_next;
    logic [2:0] unlock_cnt_reg;
    logic [2:0] unlock_cnt_next;
    logic irq_req_reg;
    logic irq_req_next;
    logic rst_req_reg;
    logic rst_req_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic timeout;
    wdt_mode_t mode;

    // Address decode
    wire ctrl_wr = wr_i && addr_i == WDT_CTRL_ADDR;
    wire ctrl_rd = rd_i && addr_i == WDT_CTRL_ADDR;
    wire cause_wr = wr_i && addr_i == RST_CAUSE_ADDR;
    wire cause_rd = rd_i && addr_i == RST_CAUSE_ADDR;

    // Effective enables after fuse and reset flag overrides
    wire unlock = unlock_cnt_reg != UNLOCK_IDLE;
    wire eff_rst_en = ctrl_reg.rst_en | cause_reg.wdog | ~always_on_fuse_i;
    wire eff_irq_en = ctrl_reg.irq_en & always_on_fuse_i;
    assign mode = decode_mode(always_on_fuse_i, eff_rst_en, eff_irq_en);
    wire run = mode != MODE_STOPPED;

    // Time-out actions per mode
    wire irq_mode_to = timeout && mode == MODE_IRQ;
    wire comb_first = timeout && mode == MODE_IRQ_RESET && !ctrl_reg.irq_flag;
    wire to_irq = irq_mode_to || comb_first;
    wire comb_second = timeout && mode == MODE_IRQ_RESET && ctrl_reg.irq_flag;
    wire to_rst = (timeout && mode == MODE_RESET) || comb_second;
    wire comb_ack = irq_ack_i && mode == MODE_IRQ_RESET;

    // Write data fields
    wire [3:0] wr_sel = {wdata_i[SEL3_BIT], wdata_i[SEL_HI_BIT:SEL_LO_BIT]};
    wire wr_unlock = ctrl_wr && wdata_i[UNLOCK_BIT];
    wire irq_flag_clr = (ctrl_wr && wdata_i[IRQ_FLAG_BIT]) || irq_ack_i;

    // Control register next value
    assign ctrl_next.irq_flag = to_irq || (ctrl_reg.irq_flag && !irq_flag_clr);
    assign ctrl_next.irq_en = comb_ack ? 1'b0 :
                              ctrl_wr ? wdata_i[IRQ_EN_BIT] : ctrl_reg.irq_en;
    assign ctrl_next.rst_en = cause_reg.wdog ||
                              (ctrl_wr ? (wdata_i[RST_EN_BIT] || (ctrl_reg.rst_en && !unlock))
                                       : ctrl_reg.rst_en);
    assign ctrl_next.sel = (ctrl_wr && unlock) ? wr_sel : ctrl_reg.sel;

    // Change window countdown
    assign unlock_cnt_next = wr_unlock ? UNLOCK_CYCLES :
                             unlock ? unlock_cnt_reg - 3'h1 : unlock_cnt_reg;

    // Reset cause flags: a new event wins over a write of zero
    assign cause_next.debug = rst_src_i.debug ||
                              (cause_reg.debug && !(cause_wr && !wdata_i[DEBUG_FLAG_BIT]));
    assign cause_next.wdog = to_rst ||
                             (cause_reg.wdog && !(cause_wr && !wdata_i[WDOG_FLAG_BIT]));
    assign cause_next.brownout = rst_src_i.brownout ||
                                 (cause_reg.brownout &&
                                  !(cause_wr && !wdata_i[BROWNOUT_FLAG_BIT]));
    assign cause_next.ext = rst_src_i.ext ||
                            (cause_reg.ext && !(cause_wr && !wdata_i[EXT_FLAG_BIT]));
    assign cause_next.poweron = cause_reg.poweron &&
                                !(cause_wr && !wdata_i[POWERON_FLAG_BIT]);

    // Requests to the CPU and the reset generator
    assign irq_req_next = gie_i && eff_irq_en && ctrl_reg.irq_flag;
    assign rst_req_next = to_rst;

    // Read views; unmapped addresses read zero
    wire [7:0] ctrl_view = {ctrl_reg.irq_flag, eff_irq_en, ctrl_reg.sel[3], unlock,
                            eff_rst_en, ctrl_reg.sel[2:0]};
    wire [7:0] cause_view = {3'h0, cause_reg};
    assign rdata_next = ctrl_rd ? ctrl_view : cause_rd ? cause_view : 8'h00;

    // State registers; only power-on reset loads their reset values
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ctrl_reg <= wdt_ctrl_t'({WDT_CTRL_RESET[IRQ_FLAG_BIT], WDT_CTRL_RESET[IRQ_EN_BIT],
                                     WDT_CTRL_RESET[RST_EN_BIT], SEL_RESET});
            cause_reg <= CAUSE_RESET;
            unlock_cnt_reg <= UNLOCK_IDLE;
        end else begin
            ctrl_reg <= ctrl_next;
            cause_reg <= cause_next;
            unlock_cnt_reg <= unlock_cnt_next;
        end
    end

    // Output registers
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            irq_req_reg <= 1'b0;
            rst_req_reg <= 1'b0;
            rdata_reg <= 8'h00;
        end else begin
            irq_req_reg <= irq_req_next;
            rst_req_reg <= rst_req_next;
            rdata_reg <= rdata_next;
        end
    end

    assign irq_req_o = irq_req_reg;
    assign sys_rst_req_o = rst_req_reg;
    assign rdata_o = rdata_reg;

    // Time-out counter
    wdt_timeout_counter #(
        .BASE_CYCLES_P(BASE_OSC_CYCLES_P)
    ) u_counter (
        .sys_clk_i(sys_clk_i),
        .srst_i(srst_i),
        .osc_clk_i(osc_clk_i),
        .run_i(run),
        .restart_i(restart_i || rst_req_reg),
        .sel_i(ctrl_reg.sel),
        .timeout_o(timeout)
    );

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    sequence s_unlock_write;
        ctrl_wr && wdata_i[UNLOCK_BIT];
    endsequence

    sequence s_quiet_window;
        (!(ctrl_wr && wdata_i[UNLOCK_BIT]))[*4];
    endsequence

    property p_unlock_hold;
        s_unlock_write |=> unlock[*4];
    endproperty
    a_unlock_hold: assert property (p_unlock_hold) else $error("unlock window short");

    property p_unlock_expire;
        s_unlock_write ##1 s_quiet_window |=> !unlock;
    endproperty
    a_unlock_expire: assert property (p_unlock_expire) else $error("unlock not cleared");

    property p_sel_locked;
        ctrl_wr && !unlock |=> $stable(ctrl_reg.sel);
    endproperty
    a_sel_locked: assert property (p_sel_locked) else $error("select changed locked");

    property p_wdog_forces_en;
        ctrl_rd && cause_reg.wdog |=> rdata_o[RST_EN_BIT];
    endproperty
    a_wdog_forces_en: assert property (p_wdog_forces_en) else $error("enable not forced");

    property p_fuse_reset_mode;
        !always_on_fuse_i |-> mode == MODE_RESET;
    endproperty
    a_fuse_reset_mode: assert property (p_fuse_reset_mode) else $error("fuse ignored");

    property p_fuse_lock_view;
        ctrl_rd && !always_on_fuse_i |=> rdata_o[RST_EN_BIT] && !rdata_o[IRQ_EN_BIT];
    endproperty
    a_fuse_lock_view: assert property (p_fuse_lock_view) else $error("fuse lock view");

    property p_irq_request;
        (gie_i && eff_irq_en && ctrl_reg.irq_flag) |=> irq_req_o;
    endproperty
    a_irq_request: assert property (p_irq_request) else $error("irq not requested");

    property p_no_irq_without_en;
        !ctrl_reg.irq_en |=> !irq_req_o;
    endproperty
    a_no_irq_without_en: assert property (p_no_irq_without_en) else $error("irq while off");

    property p_irq_mode;
        timeout && mode == MODE_IRQ |=> ctrl_reg.irq_flag && !sys_rst_req_o;
    endproperty
    a_irq_mode: assert property (p_irq_mode) else $error("irq mode action");

    property p_reset_action;
        to_rst |=> sys_rst_req_o && cause_reg.wdog ##1 !sys_rst_req_o;
    endproperty
    a_reset_action: assert property (p_reset_action) else $error("reset action");

    property p_second_timeout;
        comb_second |=> sys_rst_req_o;
    endproperty
    a_second_timeout: assert property (p_second_timeout) else $error("no second reset");

    property p_ack_fallback;
        comb_ack && !to_irq |=> !ctrl_reg.irq_en && !ctrl_reg.irq_flag && mode == MODE_RESET;
    endproperty
    a_ack_fallback: assert property (p_ack_fallback) else $error("no fall-back");

    property p_debug_flag;
        rst_src_i.debug |=> cause_reg.debug;
    endproperty
    a_debug_flag: assert property (p_debug_flag) else $error("debug flag lost");

    property p_brownout_clear;
        cause_wr && !wdata_i[BROWNOUT_FLAG_BIT] && !rst_src_i.brownout |=> !cause_reg.brownout;
    endproperty
    a_brownout_clear: assert property (p_brownout_clear) else $error("brownout clear");

    property p_ext_flag;
        rst_src_i.ext |=> cause_reg.ext;
    endproperty
    a_ext_flag: assert property (p_ext_flag) else $error("external flag lost");

    property p_poweron_flag;
        $fell(srst_i) |-> cause_reg.poweron && !cause_reg.wdog;
    endproperty
    a_poweron_flag: assert property (p_poweron_flag) else $error("power-on flag");

    property p_ack_clr_flag;
        irq_ack_i && !to_irq |=> !ctrl_reg.irq_flag;
    endproperty
    a_ack_clr_flag: assert property (p_ack_clr_flag) else $error("ack ignored");

    property p_wr_clr_flag;
        ctrl_wr && wdata_i[IRQ_FLAG_BIT] && !to_irq |=> !ctrl_reg.irq_flag;
    endproperty
    a_wr_clr_flag: assert property (p_wr_clr_flag) else $error("flag kept");

    property p_comb_first;
        comb_first |=> ctrl_reg.irq_flag && !sys_rst_req_o;
    endproperty
    a_comb_first: assert property (p_comb_first) else $error("first not irq");

    property p_wdog_clear;
        cause_wr && !wdata_i[WDOG_FLAG_BIT] && !to_rst |=> !cause_reg.wdog;
    endproperty
    a_wdog_clear: assert property (p_wdog_clear) else $error("wdog flag kept");

    property p_por_keep;
        !cause_wr |=> $stable(cause_reg.poweron);
    endproperty
    a_por_keep: assert property (p_por_keep) else $error("power-on lost");

    property p_stop_idle;
        mode == MODE_STOPPED |=> !timeout && !sys_rst_req_o;
    endproperty
    a_stop_idle: assert property (p_stop_idle) else $error("stopped acted");

    property p_rst_en_keep;
        ctrl_wr && !unlock && ctrl_reg.rst_en |=> ctrl_reg.rst_en;
    endproperty
    a_rst_en_keep: assert property (p_rst_en_keep) else $error("enable cleared");

    property p_fuse_no_irq;
        !always_on_fuse_i |=> !irq_req_o;
    endproperty
    a_fuse_no_irq: assert property (p_fuse_no_irq) else $error("irq with fuse");

    property p_bo_flag;
        rst_src_i.brownout |=> cause_reg.brownout;
    endproperty
    a_bo_flag: assert property (p_bo_flag) else $error("brownout lost");

    property p_irq_keep_en;
        irq_ack_i && mode == MODE_IRQ && !ctrl_wr |=> ctrl_reg.irq_en;
    endproperty
    a_irq_keep_en: assert property (p_irq_keep_en) else $error("enable dropped");

endmodule

//--- design/wdt_timeout_counter.sv
// Watchdog time-out counter running on sampled oscillator edges
`timescale 1ns/1ps
module wdt_timeout_counter
    import wdt_pkg::*;
#(
    parameter int BASE_CYCLES_P = BASE_OSC_CYCLES
) (
    input wire logic sys_clk_i, // System clock
    input wire logic srst_i, // Synchronous reset
    input wire logic osc_clk_i, // Watchdog oscillator level
    input wire logic run_i, // Watchdog not stopped
    input wire logic restart_i, // Restart instruction pulse
    input wire logic [3:0] sel_i, // Time-out select
    output logic timeout_o // One-cycle time-out pulse
);

    // Elaboration checks
    if (BASE_CYCLES_P < 2 || BASE_CYCLES_P > BASE_OSC_CYCLES) begin : g_bad_base
        $error("BASE_CYCLES_P out of range");
    end
    if (SYS_HZ < 4 * OSC_HZ) begin : g_bad_rate
        $error("System clock too slow to sample the oscillator");
    end

    logic osc_meta_reg;
    logic osc_sync_reg;
    logic osc_prev_reg;
    logic [CNT_W-1:0] count_reg;
    logic [CNT_W-1:0] count_next;
    logic timeout_reg;
    logic timeout_next;

    // Oscillator level synchroniser and edge history
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            osc_meta_reg <= 1'b0;
            osc_sync_reg <= 1'b0;
            osc_prev_reg <= 1'b0;
        end else begin
            osc_meta_reg <= osc_clk_i;
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    // Edge detect, limit and count step
    wire osc_edge = osc_sync_reg & ~osc_prev_reg;
    wire [CNT_W-1:0] limit = timeout_limit(BASE_CYCLES_P, sel_i);
    wire at_limit = count_reg >= limit;
    wire hold = !run_i || restart_i;
    assign count_next = hold ? '0 : !osc_edge ? count_reg : at_limit ? '0 : count_reg + 1'b1;
    assign timeout_next = !hold && osc_edge && at_limit;

    // Counter and time-out pulse
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            count_reg <= '0;
            timeout_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            timeout_reg <= timeout_next;
        end
    end

    assign timeout_o = timeout_reg;

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (srst_i);

    property p_hold_cleared;
        !run_i |=> count_reg == '0 && !timeout_o;
    endproperty
    a_hold_cleared: assert property (p_hold_cleared) else $error("counter not held");

    property p_restart;
        restart_i |=> count_reg == '0 && !timeout_o;
    endproperty
    a_restart: assert property (p_restart) else $error("restart ignored");

    property p_one_per_edge;
        timeout_o |-> $past(osc_edge) && !osc_edge && !$past(timeout_o);
    endproperty
    a_one_per_edge: assert property (p_one_per_edge) else $error("timeout not edge");

    property p_timeout_at_limit;
        (run_i && !restart_i && osc_edge && count_reg == limit) |=> timeout_o;
    endproperty
    a_timeout_at_limit: assert property (p_timeout_at_limit) else $error("timeout missed");

endmodule

//--- test/wdt_cpu_model.sv
// Model of the CPU interrupt logic and the system reset generator
`timescale 1ns/1ps
module wdt_cpu_model
    import wdt_pkg::*;
(
    input wire logic sys_clk_i, // System clock
    input wire logic srst_i, // Power-on reset
    input wire logic irq_req_i, // Interrupt request from the watchdog
    input wire logic sys_rst_req_i, // Watchdog reset request
    input wire logic ack_en_i, // Vector may be taken
    input wire logic [3:0] ack_dly_i, // Cycles before the vector runs
    input wire reset_src_t src_cmd_i, // Reset events to report
    output logic irq_ack_o, // Vector executed pulse
    output reset_src_t rst_src_o, // Reset events, one cycle each
    output int rst_cnt_o // Watchdog resets seen
);
    logic [4:0] wait_reg;

    // Vector runs after the chosen delay; the tail of the count is a hold-off
    // so a request that is still falling is not taken twice
    always_ff @(posedge sys_clk_i) begin
        irq_ack_o <= 1'b0;
        rst_src_o <= src_cmd_i;
        if (srst_i) begin
            wait_reg <= 5'h00;
            rst_cnt_o <= 0;
        end else begin
            if (sys_rst_req_i) begin
                rst_cnt_o <= rst_cnt_o + 1;
            end
            if (wait_reg != 5'h00) begin
                wait_reg <= wait_reg - 5'h01;
            end else if (irq_req_i && ack_en_i) begin
                wait_reg <= {1'b0, ack_dly_i} + 5'h05;
            end
            if (wait_reg == 5'h05) begin
                irq_ack_o <= 1'b1;
            end
        end
    end
endmodule

//--- test/wdt_reset_cause_tb.sv
// Self-checking bench for the watchdog control and reset cause block
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] t=%0t got %h exp %h", $time, (g), (e)); end end
module wdt_reset_cause_tb;
    import wdt_pkg::*;
    localparam int BASE = 2;
    logic sys_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic osc_clk_i = 1'b0;
    logic restart_i = 1'b0;
    logic gie_i = 1'b0;
    logic irq_ack_i;
    logic always_on_fuse_i = 1'b1;
    reset_src_t rst_src_i;
    reset_src_t src_cmd = '0;
    logic irq_req_o;
    logic sys_rst_req_o;
    logic ack_en = 1'b0;
    logic [3:0] ack_dly = 4'h2;
    int rst_cnt;
    int error_cnt = 0;
    int tests_run = 0;
    int cyc = 0;
    int osc_edges = 0;
    int e0;
    bit osc_run = 1'b0;
    logic [3:0] sels [4] = '{4'h0, 4'h1, 4'h2, 4'h9};
    logic [7:0] src_exp [3] = '{8'h02, 8'h04, 8'h10};
    logic [7:0] cexp;

    wdt_reset_cause #(.BASE_OSC_CYCLES_P(BASE)) u_wdt_reset_cause (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .osc_clk_i(osc_clk_i),
        .restart_i(restart_i), .gie_i(gie_i), .irq_ack_i(irq_ack_i),
        .always_on_fuse_i(always_on_fuse_i), .rst_src_i(rst_src_i),
        .irq_req_o(irq_req_o), .sys_rst_req_o(sys_rst_req_o));
    wdt_cpu_model u_wdt_cpu_model (
        .sys_clk_i(sys_clk_i), .srst_i(srst_i), .irq_req_i(irq_req_o),
        .sys_rst_req_i(sys_rst_req_o), .ack_en_i(ack_en), .ack_dly_i(ack_dly),
        .src_cmd_i(src_cmd), .irq_ack_o(irq_ack_i), .rst_src_o(rst_src_i),
        .rst_cnt_o(rst_cnt));

    // Clocks: the oscillator stands still while the register tests run
    always #5 sys_clk_i = ~sys_clk_i;
    always #36 if (osc_run) osc_clk_i = ~osc_clk_i;
    always @(posedge osc_clk_i) osc_edges++;

    // Hang guard
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        `CHK(rdata_o, e)
    endtask

    // Waits a bounded time for a request or a reset pulse
    task automatic wait_ev(input bit use_irq);
        int n = 0;
        do begin
            @(posedge sys_clk_i);
            #1;
            n++;
        end while (((use_irq ? irq_req_o : sys_rst_req_o) !== 1'b1) && n < 20000);
        `CHK(n < 20000, 1'b1)
    endtask

    // Unlocked write: unlock with reset enable, then the new value
    task automatic wr_unl(input logic [7:0] d);
        wr(WDT_CTRL_ADDR, 8'h18);
        wr(WDT_CTRL_ADDR, d);
        // Let the change window run out so read-backs see the unlock bit low
        repeat (2) @(posedge sys_clk_i);
    endtask

    initial begin
        repeat (6) @(posedge sys_clk_i);
        srst_i <= 1'b0;
        rd(WDT_CTRL_ADDR, 8'h00);
        rd(RST_CAUSE_ADDR, 8'h01);
        rd(8'h33, 8'h00);
        // Each reset source sets its own flag; write zero clears all
        cexp = 8'h01;
        for (int i = 0; i < 3; i++) begin
            @(posedge sys_clk_i);
            src_cmd <= reset_src_t'(3'h1 << i);
            @(posedge sys_clk_i);
            src_cmd <= '0;
            cexp = cexp | src_exp[i];
            rd(RST_CAUSE_ADDR, cexp);
        end
        wr(RST_CAUSE_ADDR, 8'h00);
        rd(RST_CAUSE_ADDR, 8'h00);
        $display("cause flags done");
        // Change window
        wr(WDT_CTRL_ADDR, 8'h08);
        rd(WDT_CTRL_ADDR, 8'h08);
        wr(WDT_CTRL_ADDR, 8'h01);
        rd(WDT_CTRL_ADDR, 8'h08);
        wr(WDT_CTRL_ADDR, 8'h18);
        rd(WDT_CTRL_ADDR, 8'h18);
        wr_unl(8'h01);
        rd(WDT_CTRL_ADDR, 8'h01);
        wr(WDT_CTRL_ADDR, 8'h18);
        repeat (3) @(posedge sys_clk_i);
        rd(WDT_CTRL_ADDR, 8'h09);
        wr(WDT_CTRL_ADDR, 8'h00);
        rd(WDT_CTRL_ADDR, 8'h09);
        $display("change window done");
        // Time-out length in oscillator cycles, measured between resets
        foreach (sels[k]) begin
            wr_unl({2'b00, sels[k][3], 2'b01, sels[k][2:0]});
            osc_run = 1'b1;
            wait_ev(1'b0);
            e0 = osc_edges;
            wait_ev(1'b0);
            `CHK(osc_edges - e0, BASE << sels[k])
            osc_run = 1'b0;
        end
        rd(RST_CAUSE_ADDR, 8'h08);
        wr_unl(8'h00);
        rd(WDT_CTRL_ADDR, 8'h08);
        wr(RST_CAUSE_ADDR, 8'h00);
        wr_unl(8'h00);
        rd(WDT_CTRL_ADDR, 8'h00);
        $display("reset mode done");
        // Interrupt mode
        wr(WDT_CTRL_ADDR, 8'h40);
        e0 = rst_cnt;
        osc_run = 1'b1;
        repeat (40) @(posedge sys_clk_i);
        osc_run = 1'b0;
        rd(WDT_CTRL_ADDR, 8'hc0);
        `CHK(irq_req_o, 1'b0)
        @(posedge sys_clk_i);
        gie_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        `CHK(irq_req_o, 1'b1)
        wr(WDT_CTRL_ADDR, 8'hc0);
        rd(WDT_CTRL_ADDR, 8'h40);
        `CHK(irq_req_o, 1'b0)
        ack_en <= 1'b1;
        osc_run = 1'b1;
        wait_ev(1'b1);
        osc_run = 1'b0;
        repeat (12) @(posedge sys_clk_i);
        rd(WDT_CTRL_ADDR, 8'h40);
        `CHK(rst_cnt, e0)
        $display("interrupt mode done");
        // Combined mode: vector falls back to reset, missed vector resets
        wr(WDT_CTRL_ADDR, 8'h48);
        osc_run = 1'b1;
        wait_ev(1'b1);
        repeat (6) @(posedge sys_clk_i);
        rd(WDT_CTRL_ADDR, 8'h08);
        wait_ev(1'b0);
        osc_run = 1'b0;
        @(posedge sys_clk_i);
        ack_en <= 1'b0;
        wr(WDT_CTRL_ADDR, 8'h48);
        e0 = rst_cnt;
        osc_run = 1'b1;
        wait_ev(1'b0);
        osc_run = 1'b0;
        rd(WDT_CTRL_ADDR, 8'hc8);
        `CHK(rst_cnt, e0 + 1)
        wr(RST_CAUSE_ADDR, 8'h00);
        wr(WDT_CTRL_ADDR, 8'h80);
        wr_unl(8'h00);
        rd(WDT_CTRL_ADDR, 8'h00);
        $display("combined mode done");
        // Programmed fuse forces reset mode
        @(posedge sys_clk_i);
        always_on_fuse_i <= 1'b0;
        wr(WDT_CTRL_ADDR, 8'h40);
        rd(WDT_CTRL_ADDR, 8'h08);
        e0 = rst_cnt;
        osc_run = 1'b1;
        wait_ev(1'b0);
        osc_run = 1'b0;
        // The model counts the reset pulse one edge after it appears
        @(posedge sys_clk_i);
        #1;
        `CHK(rst_cnt, e0 + 1)
        @(posedge sys_clk_i);
        always_on_fuse_i <= 1'b1;
        wr(WDT_CTRL_ADDR, 8'h80);
        $display("fuse done");
        // Restarts faster than the period keep resets away
        e0 = rst_cnt;
        osc_run = 1'b1;
        repeat (40) begin
            @(posedge sys_clk_i);
            restart_i <= 1'b1;
            @(posedge sys_clk_i);
            restart_i <= 1'b0;
            repeat (3) @(posedge sys_clk_i);
        end
        `CHK(rst_cnt, e0)
        wait_ev(1'b0);
        osc_run = 1'b0;
        // Stopped watchdog does nothing
        wr(RST_CAUSE_ADDR, 8'h00);
        wr_unl(8'h00);
        e0 = rst_cnt;
        osc_run = 1'b1;
        repeat (300) @(posedge sys_clk_i);
        osc_run = 1'b0;
        `CHK(rst_cnt, e0)
        rd(WDT_CTRL_ADDR, 8'h00);
        $display("restart and stop done");
        end_of_test();
    end
endmodule
